// *** logic/clb_pkg.sv ***
// Shared constants for the processor local bus pin control block
package clb_pkg;

  // Processor address pin count
  localparam int unsigned ADDR_W = 24;

  // Pins turned round during refresh and DMA only: 21 and 19 down to 1
  localparam logic [23:0] ADDR_DMA_MASK = 24'h2ffffe;
  // Pins turned round during refresh, DMA and bus-master: 20 and 0
  localparam logic [23:0] ADDR_ALL_MASK = 24'h100001;

  // Layout of the synchronised pin vector
  localparam int unsigned SYNC_W      = 32;
  localparam int unsigned POS_S1      = 24;
  localparam int unsigned POS_S0      = 25;
  localparam int unsigned POS_EXT_ACK = 26;
  localparam int unsigned POS_HBE     = 27;
  localparam int unsigned POS_SX      = 28;
  localparam int unsigned POS_BUSY    = 29;
  localparam int unsigned POS_AT_A0   = 30;
  localparam int unsigned POS_HOLD    = 31;

  // Reset values of the decoded outputs (inactive levels)
  localparam logic RST_HIGH = 1'h1;
  localparam logic RST_LOW  = 1'h0;

  // Who owns the address and byte-enable pins this cycle
  typedef enum logic [1:0] {
    CLB_OWN_CPU,
    CLB_OWN_DMA,
    CLB_OWN_MASTER
  } clb_owner_t;

endpackage

// *** logic/clb_sync.sv ***
// Two-stage synchroniser for a vector of pin levels
module clb_sync #(
  parameter int unsigned WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  // Pins and their synchronised copies
  input  wire logic [WIDTH-1:0] pins_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  ////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second, nothing else looks at it
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= pins_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

// *** logic/clb_pin_ctrl.sv ***
// Processor local bus pin direction and mode decode
module clb_pin_ctrl
  import clb_pkg::*;
#(
  parameter bit LOW_END = 1'b0
) (
  // Clock and reset
  input  wire logic                        clk_in,
  input  wire logic                        resetn_in,
  // Processor pins, asynchronous
  input  wire logic                        status_one_in,
  input  wire logic                        status_zero_in,
  input  wire logic                        extension_ack_n_in,
  input  wire logic                        hold_grant_in,
  input  wire logic                        sx_mode_in,
  input  wire logic                        copro_busy_in,
  input  wire logic                        at_addr0_in,
  // Two-way processor pins
  input  wire logic                        high_byte_enable_in,
  output logic                             high_byte_enable_out,
  output logic                             high_byte_enable_oe_n_out,
  input  wire logic [clb_pkg::ADDR_W-1:0]  proc_addr_in,
  output logic      [clb_pkg::ADDR_W-1:0]  proc_addr_out,
  output logic      [clb_pkg::ADDR_W-1:0]  proc_addr_oe_n_out,
  // Internal cycle requests, same clock
  input  wire logic                        refresh_cycle_in,
  input  wire logic                        dma_cycle_in,
  input  wire logic                        master_cycle_in,
  input  wire logic [clb_pkg::ADDR_W-1:0]  dma_addr_in,
  input  wire logic                        dma_high_byte_in,
  // Decoded processor status
  output logic                             proc_status_one_n_out,
  output logic                             write_cycle_out,
  output logic                             proc_status_zero_n_out,
  output logic                             address_strobe_n_out,
  output logic                             copro_ack_n_out,
  output logic                             data_cycle_out,
  output logic                             upper_byte_xfer_out,
  output logic                             addr_bit0_out,
  output logic                             low_byte_enable_n_out,
  output logic      [clb_pkg::ADDR_W-1:0]  sampled_addr_out,
  output logic                             cpu_copro_busy_out
);

  logic [SYNC_W-1:0] pins_s;
  logic              sx_s;
  logic              hold_s;
  clb_owner_t        owner;

  ////////////////////////////////////////////////////////////////////////
  // Every pin passes two flops before use
  clb_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .pins_in   ({hold_grant_in, at_addr0_in, copro_busy_in, sx_mode_in, high_byte_enable_in,
                 extension_ack_n_in, status_zero_in, status_one_in, proc_addr_in}),
    .sync_out  (pins_s)
  );

  assign sx_s   = pins_s[POS_SX];
  assign hold_s = pins_s[POS_HOLD];

  ////////////////////////////////////////////////////////////////////////
  // Pick the bus owner; no drive without hold grant, so a late grant never contends
  always_comb
  begin
    owner = CLB_OWN_CPU;
    if (hold_s && (refresh_cycle_in || dma_cycle_in))
      owner = CLB_OWN_DMA;
    else if (hold_s && master_cycle_in)
      owner = CLB_OWN_MASTER;
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin direction and driven values
  logic                  hbe_d,  hbe_q;
  logic                  hbe_oe_n_d, hbe_oe_n_q;
  logic [ADDR_W-1:0]     addr_d, addr_q;
  logic [ADDR_W-1:0]     addr_oe_n_d, addr_oe_n_q;

  always_comb
  begin
    hbe_d       = RST_LOW;
    hbe_oe_n_d  = RST_HIGH;
    addr_d      = '0;
    addr_oe_n_d = '1;
    case (owner)
      CLB_OWN_DMA:
      begin
        hbe_d       = dma_high_byte_in;
        hbe_oe_n_d  = RST_LOW;
        addr_d      = dma_addr_in;
        addr_oe_n_d = ~(ADDR_DMA_MASK | ADDR_ALL_MASK);
      end
      CLB_OWN_MASTER:
      begin
        addr_d      = dma_addr_in;
        addr_d[0]   = pins_s[POS_AT_A0];
        addr_oe_n_d = ~ADDR_ALL_MASK;
      end
      CLB_OWN_CPU:
      begin
        hbe_oe_n_d  = RST_HIGH;
      end
      default:
      begin
        hbe_oe_n_d  = RST_HIGH;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      hbe_q       <= RST_LOW;
      hbe_oe_n_q  <= RST_HIGH;
      addr_q      <= '0;
      addr_oe_n_q <= '1;
    end
    else
    begin
      hbe_q       <= hbe_d;
      hbe_oe_n_q  <= hbe_oe_n_d;
      addr_q      <= addr_d;
      addr_oe_n_q <= addr_oe_n_d;
    end
  end

  assign high_byte_enable_out      = hbe_q;
  assign high_byte_enable_oe_n_out = hbe_oe_n_q;
  assign proc_addr_out             = addr_q;
  assign proc_addr_oe_n_out        = addr_oe_n_q;

  ////////////////////////////////////////////////////////////////////////
  // Mode-dependent status decode; unused meanings sit at inactive level
  logic              st1_n_d, st1_n_q, wr_d, wr_q;
  logic              st0_n_d, st0_n_q, ads_n_d, ads_n_q;
  logic              ack_n_d, ack_n_q, dc_d, dc_q;
  logic              upper_d, upper_q, a0_d, a0_q, ble_n_d, ble_n_q;
  logic [ADDR_W-1:0] samp_d, samp_q;
  logic              busy_d, busy_q;
  logic              cpu_owns;
  logic              cpu_drives;

  assign cpu_owns = (owner == CLB_OWN_CPU);
  // Processor floats its pins once hold is granted, so sample only before that
  assign cpu_drives = cpu_owns && !hold_s;

  always_comb
  begin
    st1_n_d = sx_s ? RST_HIGH : pins_s[POS_S1];
    wr_d    = sx_s ? pins_s[POS_S1] : RST_LOW;
    st0_n_d = sx_s ? RST_HIGH : pins_s[POS_S0];
    ads_n_d = sx_s ? pins_s[POS_S0] : RST_HIGH;
    // Low-end part has no coprocessor handshake, so the pin is ignored
    ack_n_d = (!LOW_END && !sx_s) ? pins_s[POS_EXT_ACK] : RST_HIGH;
    dc_d    = (!LOW_END && sx_s) ? pins_s[POS_EXT_ACK] : RST_LOW;
    upper_d = cpu_drives ? pins_s[POS_HBE] : RST_LOW;
    a0_d    = (cpu_drives && !sx_s) ? pins_s[0] : RST_LOW;
    ble_n_d = (cpu_drives && sx_s) ? pins_s[0] : RST_HIGH;
    samp_d  = cpu_drives ? pins_s[ADDR_W-1:0] : samp_q;
    busy_d  = pins_s[POS_BUSY];
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      st1_n_q <= RST_HIGH;
      wr_q    <= RST_LOW;
      st0_n_q <= RST_HIGH;
      ads_n_q <= RST_HIGH;
      ack_n_q <= RST_HIGH;
      dc_q    <= RST_LOW;
      upper_q <= RST_LOW;
      a0_q    <= RST_LOW;
      ble_n_q <= RST_HIGH;
      samp_q  <= '0;
      busy_q  <= RST_LOW;
    end
    else
    begin
      st1_n_q <= st1_n_d;
      wr_q    <= wr_d;
      st0_n_q <= st0_n_d;
      ads_n_q <= ads_n_d;
      ack_n_q <= ack_n_d;
      dc_q    <= dc_d;
      upper_q <= upper_d;
      a0_q    <= a0_d;
      ble_n_q <= ble_n_d;
      samp_q  <= samp_d;
      busy_q  <= busy_d;
    end
  end

  assign proc_status_one_n_out  = st1_n_q;
  assign write_cycle_out        = wr_q;
  assign proc_status_zero_n_out = st0_n_q;
  assign address_strobe_n_out   = ads_n_q;
  assign copro_ack_n_out        = ack_n_q;
  assign data_cycle_out         = dc_q;
  assign upper_byte_xfer_out    = upper_q;
  assign addr_bit0_out          = a0_q;
  assign low_byte_enable_n_out  = ble_n_q;
  assign sampled_addr_out       = samp_q;
  assign cpu_copro_busy_out     = busy_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks on direction and decode
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  a_write_sx_decode: assert property (sx_s |=> (write_cycle_out == $past(pins_s[POS_S1])))
    else $error("write indicator not taken from status one in SX mode");
  a_strobe_decode: assert property (!sx_s |=> address_strobe_n_out && (proc_status_zero_n_out == $past(pins_s[POS_S0])))
    else $error("status zero decode wrong in word mode");
  a_upper_sample: assert property (cpu_drives |=> (upper_byte_xfer_out == $past(pins_s[POS_HBE])) && high_byte_enable_oe_n_out)
    else $error("high byte enable not sampled while cpu owns bus");
  a_hbe_dma_drive: assert property ((owner == CLB_OWN_DMA) |=> !high_byte_enable_oe_n_out && (high_byte_enable_out == $past(dma_high_byte_in)))
    else $error("high byte enable not driven in dma");
  a_ext_ack_decode: assert property (sx_s |=> copro_ack_n_out && (data_cycle_out == (!LOW_END && $past(pins_s[POS_EXT_ACK]))))
    else $error("extension acknowledge decode wrong");
  a_busy_follow: assert property ($stable(copro_busy_in)[*4] |=> (cpu_copro_busy_out == $past(copro_busy_in, 4)))
    else $error("busy output does not follow coprocessor busy");
  a_master_bit0: assert property ((owner == CLB_OWN_MASTER) |=> (proc_addr_out[0] == $past(pins_s[POS_AT_A0])) && !proc_addr_oe_n_out[0])
    else $error("address bit zero not driven from AT bit zero in master mode");
  a_addr_dma_dir: assert property ((owner == CLB_OWN_DMA) |=> ((~proc_addr_oe_n_out & 24'hffffff) == (ADDR_DMA_MASK | ADDR_ALL_MASK)))
    else $error("address direction wrong in refresh or dma");
  a_addr_master_dir: assert property ((owner == CLB_OWN_MASTER) |=> (proc_addr_oe_n_out == ~ADDR_ALL_MASK))
    else $error("address direction wrong in master mode");
  a_release_cpu: assert property (cpu_owns |=> (&proc_addr_oe_n_out) && high_byte_enable_oe_n_out)
    else $error("driver not released while cpu owns bus");

  c_dma_cycle: cover property ((owner == CLB_OWN_DMA) ##1 cpu_owns);
  c_master_cycle: cover property ((owner == CLB_OWN_MASTER) ##1 cpu_owns);
  c_sx_write: cover property (sx_s && pins_s[POS_S1] ##1 write_cycle_out);

endmodule

// *** test/clb_cpu_model.sv ***
// Host processor model: drives address and high-byte pins, floats them on hold grant
module clb_cpu_model #(
  parameter int unsigned GRANT_DLY = 2
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  // Requests from the bench
  input  wire logic        hold_req_in,
  input  wire logic [23:0] addr_in,
  input  wire logic        hbe_in,
  // Pin side
  output logic             hold_grant_out,
  output logic [23:0]      addr_out,
  output logic             addr_en_out,
  output logic             hbe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0]  cnt_q;
  logic [23:0] addr_last_q;
  logic        hbe_last_q;

  ////////////////////////////////////////////////////////////////////////////
  // Grant after a delay; released pins show the inverse so stale values never pass
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      cnt_q          <= 4'h0;
      hold_grant_out <= 1'b0;
      addr_last_q    <= 24'h000000;
      hbe_last_q     <= 1'b0;
    end
    else
    begin
      cnt_q          <= hold_req_in ? ((cnt_q < 4'(GRANT_DLY)) ? cnt_q + 4'h1 : cnt_q) : 4'h0;
      hold_grant_out <= hold_req_in && (cnt_q == 4'(GRANT_DLY));
      if (addr_en_out)
      begin
        addr_last_q <= addr_in;
        hbe_last_q  <= hbe_in;
      end
    end
  end

  // Bus floats as soon as the grant is given
  assign addr_en_out = !hold_grant_out;
  assign addr_out    = addr_en_out ? addr_in : ~addr_last_q;
  assign hbe_out     = addr_en_out ? hbe_in : ~hbe_last_q;
endmodule

// *** test/tb_top.sv ***
// Self-checking bench for the local bus pin control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import clb_pkg::*;
  logic clk_in = 1'b0, resetn_in = 1'b0, s1 = 1'b0, s0 = 1'b1, ack = 1'b1, sx = 1'b0, busy = 1'b0;
  logic at_a0 = 1'b0, hold_req = 1'b0, refr = 1'b0, dma = 1'b0, mst = 1'b0, dma_hb = 1'b1, cpu_hbe = 1'b0;
  logic [23:0] cpu_addr = 24'h000000, dma_addr = 24'h000000, cpu_pins, blk_out, oe_n, pins, smp;
  logic grant, cpu_en, cpu_hb_pin, hbe_o, hbe_oe_n, ps1, wr, ps0, ads, cack, dcy, ubx, ab0, lbe, cbusy;
  int fails = 0, checks = 0;
  logic [6:0] row_in [4] = '{7'b0010111, 7'b0101000, 7'b1101110, 7'b1010001};
  logic [9:0] row_ex [4] = '{10'b0011001111, 10'b1001100010, 10'b1110111001, 10'b1011100010};

  ////////////////////////////////////////////////////////////////////////////
  // Clock, pin resolution and instances
  initial forever #50 clk_in = ~clk_in;
  assign pins = (~oe_n & blk_out) | (oe_n & cpu_pins);

  clb_cpu_model i_clb_cpu_model (.clk_in(clk_in), .resetn_in(resetn_in), .hold_req_in(hold_req),
    .addr_in(cpu_addr), .hbe_in(cpu_hbe), .hold_grant_out(grant), .addr_out(cpu_pins),
    .addr_en_out(cpu_en), .hbe_out(cpu_hb_pin));

  clb_pin_ctrl i_clb_pin_ctrl (.clk_in(clk_in), .resetn_in(resetn_in), .status_one_in(s1),
    .status_zero_in(s0), .extension_ack_n_in(ack), .hold_grant_in(grant), .sx_mode_in(sx),
    .copro_busy_in(busy), .at_addr0_in(at_a0), .high_byte_enable_in(hbe_oe_n ? cpu_hb_pin : hbe_o),
    .high_byte_enable_out(hbe_o), .high_byte_enable_oe_n_out(hbe_oe_n), .proc_addr_in(pins),
    .proc_addr_out(blk_out), .proc_addr_oe_n_out(oe_n), .refresh_cycle_in(refr),
    .dma_cycle_in(dma), .master_cycle_in(mst), .dma_addr_in(dma_addr), .dma_high_byte_in(dma_hb),
    .proc_status_one_n_out(ps1), .write_cycle_out(wr), .proc_status_zero_n_out(ps0),
    .address_strobe_n_out(ads), .copro_ack_n_out(cack), .data_cycle_out(dcy),
    .upper_byte_xfer_out(ubx), .addr_bit0_out(ab0), .low_byte_enable_n_out(lbe),
    .sampled_addr_out(smp), .cpu_copro_busy_out(cbusy));

  ////////////////////////////////////////////////////////////////////////////
  // Compare, wait and closing tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic stop_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Processor driving while the block drives is a contention fault
  always @(negedge clk_in)
    if (resetn_in && cpu_en && (oe_n !== 24'hffffff || hbe_oe_n !== 1'b1))
      check(32'h1, 32'h0);

  initial
  begin
    #200us;
    fails++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    cyc(3);
    check({hbe_oe_n, oe_n}, 32'h01ffffff);
    resetn_in <= 1'b1;
    // Decode table: mode, status pins, ack, busy, hbe, a0
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_in);
      {sx, s1, s0, ack, busy, cpu_hbe, cpu_addr[0]} <= row_in[i];
      cpu_addr[23:1] <= 23'h2a5a5a + 23'(i);
      cyc(4);
      check({ps1, wr, ps0, ads, cack, dcy, ubx, ab0, lbe, cbusy}, row_ex[i]);
      check(smp, {23'h2a5a5a + 23'(i), row_in[i][0]});
    end
    // Cycle request without hold grant is refused
    @(posedge clk_in);
    dma <= 1'b1;
    dma_addr <= 24'ha5c3e1;
    dma_hb <= 1'b0;
    cyc(3);
    check({hbe_oe_n, oe_n}, 32'h01ffffff);
    // Hold granted: DMA then refresh drive bits 21..0 and high byte enable
    @(posedge clk_in);
    hold_req <= 1'b1;
    cyc(7);
    check({hbe_oe_n, oe_n}, 32'h00c00000);
    check({hbe_o, blk_out & 24'h3fffff}, {1'b0, 24'h25c3e1});
    check({ubx, ab0, lbe}, 3'b001);
    @(posedge clk_in);
    dma <= 1'b0;
    refr <= 1'b1;
    mst <= 1'b1;
    dma_hb <= 1'b1;
    cyc(2);
    check({hbe_oe_n, oe_n, hbe_o}, {25'h0c00000, 1'b1});
    // Bus master: only bits 20 and 0, bit 0 from AT bus
    @(posedge clk_in);
    refr <= 1'b0;
    at_a0 <= 1'b0;
    // Bit 20 set so the driven level shows, bit 0 set so AT bit zero is told apart
    dma_addr <= 24'hb5c3e1;
    cyc(4);
    check({hbe_oe_n, oe_n}, 32'h01effffe);
    check(blk_out & 24'h100001, 24'h100000);
    @(posedge clk_in);
    at_a0 <= 1'b1;
    cyc(4);
    check(blk_out & 24'h100001, 24'h100001);
    // Release: everything back to inputs, processor retakes the bus
    @(posedge clk_in);
    mst <= 1'b0;
    cyc(2);
    check({hbe_oe_n, oe_n}, 32'h01ffffff);
    @(posedge clk_in);
    hold_req <= 1'b0;
    cyc(6);
    check(smp, cpu_addr);
    // Reset in mid-transfer releases all drivers
    @(posedge clk_in);
    hold_req <= 1'b1;
    dma <= 1'b1;
    cyc(8);
    resetn_in <= 1'b0;
    hold_req <= 1'b0;
    dma <= 1'b0;
    cyc(1);
    check({hbe_oe_n, oe_n}, 32'h01ffffff);
    stop_test();
  end
endmodule
